/* File: src/ebm_pkg.sv */
// Purpose: Shared constants, types and helpers for the embedded block memory.
// Assumes: One clock for both ports; configuration inputs are static while in use.
// Notes: Widths are coded 1, 2, 4, 9 and 18 bits; the array holds 9,216 bits.
// Behaviour
// [RQ1] Single, true dual, pseudo dual and FIFO modes; 8Kx1, 4Kx2, 2Kx4, 1Kx9 in all.
// [RQ2] 512x18 allowed only in pseudo dual port and FIFO modes.
// [RQ3] In multi-port modes each port may use its own data width on shared storage.
// [RQ4] Bits run LSB to MSB of word 0, then word 1, for every port width.
// [RQ5] Contents may optionally be loaded at start-up from the user flash store.
// [RQ6] An all-zero initial image reads no user flash store bits.
// [RQ7] Blocks with the same image read it from one shared flash region.
// [RQ8] For ROM use the user preloads and keeps the write controls off.
// [RQ9] Write data and address of each port are registered before array access.
// [RQ10] Optional output register adds exactly one clock of read latency.
// [RQ11] Larger memories cascade blocks through port selects and ORed read data.
// [RQ12] In true dual port each port has its own enable, address, write and data lines.
package ebm_pkg;

    localparam int          EBM_DW        = 18;
    localparam int          EBM_OW        = 14;
    localparam int          EBM_AW        = 13;
    localparam int          EBM_FW        = 16;
    localparam int          EBM_BITS      = 9216;
    localparam logic [8:0]  EBM_INIT_LAST = 9'h1ff;
    localparam logic [9:0]  EBM_LOAD_MAX  = 10'h0208;

    typedef enum logic [3:0] {
        MODE_SINGLE = 4'h1,
        MODE_TDP    = 4'h2,
        MODE_PDP    = 4'h4,
        MODE_FIFO   = 4'h8
    } ebm_mode_t;

    typedef enum logic [2:0] {
        WID_X1  = 3'h0,
        WID_X2  = 3'h1,
        WID_X4  = 3'h2,
        WID_X9  = 3'h3,
        WID_X18 = 3'h4
    } ebm_width_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h2
    } ebm_state_t;

    function automatic logic [4:0] ebm_bits_of(input ebm_width_t w);
        case (w)
            WID_X2:  ebm_bits_of = 5'h02;
            WID_X4:  ebm_bits_of = 5'h04;
            WID_X9:  ebm_bits_of = 5'h09;
            WID_X18: ebm_bits_of = 5'h12;
            default: ebm_bits_of = 5'h01;
        endcase
    endfunction

    function automatic logic [12:0] ebm_mask_of(input ebm_width_t w);
        case (w)
            WID_X2:  ebm_mask_of = 13'h0fff;
            WID_X4:  ebm_mask_of = 13'h07ff;
            WID_X9:  ebm_mask_of = 13'h03ff;
            WID_X18: ebm_mask_of = 13'h01ff;
            default: ebm_mask_of = 13'h1fff;
        endcase
    endfunction

endpackage

/* File: src/ebm_port.sv */
// Purpose: One port's input capture, array read latch and optional output register.
// Assumes: Requests arrive already qualified by the block's mode and select logic.
// Notes: Read data holds between reads; a deselected access clears it for cascading.
`timescale 1ns/100ps
module ebm_port #(
    parameter int DW = 18,
    parameter int OW = 14
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          rd_req,
    input  wire logic          wr_req,
    input  wire logic          desel_req,
    input  wire logic [OW-1:0] off,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          out_reg_en,
    input  wire logic [DW-1:0] arr_data,
    output logic               wr_r,
    output logic [OW-1:0]      off_r,
    output logic [DW-1:0]      wdata_r,
    output logic [DW-1:0]      rdata,
    output logic               rvalid
);

    logic          rd_r;
    logic          desel_r;
    logic [DW-1:0] rdq_r;
    logic [DW-1:0] q2_r;
    logic          v1_r;
    logic          v2_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_r    <= 1'b0;
            wr_r    <= 1'b0;
            desel_r <= 1'b0;
            off_r   <= '0;
            wdata_r <= '0;
        end else begin
            rd_r    <= rd_req;  // [RQ9]
            wr_r    <= wr_req;  // [RQ9]
            desel_r <= desel_req;
            off_r   <= off;     // [RQ9]
            wdata_r <= wdata;   // [RQ9]
        end
    end

    // A deselected port returns zero so that cascaded blocks can be ORed.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdq_r <= '0;
            q2_r  <= '0;
            v1_r  <= 1'b0;
            v2_r  <= 1'b0;
        end else begin
            if (rd_r) begin
                rdq_r <= arr_data;
            end else if (desel_r) begin
                rdq_r <= '0;    // [RQ11]
            end
            q2_r <= rdq_r;      // [RQ10]
            v1_r <= rd_r;
            v2_r <= v1_r;
        end
    end

    assign rdata  = out_reg_en ? q2_r : rdq_r;  // [RQ10]
    assign rvalid = out_reg_en ? v2_r : v1_r;

    // The registered path must show the array word seen two clocks earlier, valid with it.
    oreg_data_a: assert property (@(posedge clk) disable iff (!arst_n) // [RQ10]
        (rd_r && out_reg_en) |=> ##1 (rvalid && rdata == $past(arr_data, 2)))
        else $error("output register does not hold the previous array data");

endmodule

/* File: src/ebm_block.sv */
// Purpose: Embedded block memory with four modes, mixed port widths and preload.
// Assumes: Fabric logic drives both ports on clk; flash data returns one clock after a request.
// Notes: Mode, widths and output register selects are static; change them only in reset.
`timescale 1ns/100ps
module ebm_block
    import ebm_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  ebm_mode_t          mode,
    input  ebm_width_t         width_a,
    input  ebm_width_t         width_b,
    input  wire logic          out_reg_a,
    input  wire logic          out_reg_b,
    input  wire logic          preload_en,
    input  wire logic          preload_zero,
    input  wire logic [15:0]   image_base,
    input  wire logic          ce_a,
    input  wire logic          sel_a,
    input  wire logic          we_a,
    input  wire logic [12:0]   addr_a,
    input  wire logic [17:0]   wdata_a,
    output logic [17:0]        rdata_a,
    output logic               rvalid_a,
    input  wire logic          ce_b,
    input  wire logic          sel_b,
    input  wire logic          we_b,
    input  wire logic [12:0]   addr_b,
    input  wire logic [17:0]   wdata_b,
    output logic [17:0]        rdata_b,
    output logic               rvalid_b,
    output logic               flash_rd_req,
    output logic [15:0]        flash_addr,
    input  wire logic [17:0]   flash_rdata,
    output logic               ready,
    output logic               cfg_error,
    output logic               fifo_full,
    output logic               fifo_empty
);

    logic       mem [0:EBM_BITS-1];
    ebm_state_t state_r;
    logic [8:0] idx_r;
    logic       issued_r;
    logic       pend_r;
    logic [8:0] pend_idx_r;
    logic [13:0] wptr_r;
    logic [13:0] rptr_r;
    logic [14:0] level_r;
    logic [9:0]  load_cnt_r;

    logic          wr_ra;
    logic          wr_rb;
    logic [13:0]   off_ra;
    logic [13:0]   off_rb;
    logic [17:0]   wdata_ra;
    logic [17:0]   wdata_rb;
    logic [17:0]   arr_a;
    logic [17:0]   arr_b;

    wire logic [4:0]  wa       = ebm_bits_of(width_a);
    wire logic [4:0]  wb       = ebm_bits_of(width_b);
    wire logic        is_sp    = (mode == MODE_SINGLE);
    wire logic        is_tdp   = (mode == MODE_TDP);
    wire logic        is_pdp   = (mode == MODE_PDP);
    wire logic        is_fifo  = (mode == MODE_FIFO);
    wire logic        run      = (state_r == ST_RUN);

    // Wide words exist only where one port writes and the other reads.
    wire logic bad_sp   = is_sp && (width_a == WID_X18);                          // [RQ2]
    wire logic bad_tdp  = is_tdp && (width_a == WID_X18 || width_b == WID_X18);   // [RQ2]
    wire logic bad_code = (width_a > WID_X18) || (width_b > WID_X18);
    wire logic bad_mode = !(is_sp || is_tdp || is_pdp || is_fifo);
    wire logic cfg_ok   = !(bad_sp || bad_tdp || bad_code || bad_mode);           // [RQ1]
    wire logic go       = run && cfg_ok;

    // FIFO capacity follows the write side; mixed FIFO widths must divide it.
    wire logic [18:0] cap_prod = {6'h00, ebm_mask_of(width_a)} + 19'h0_0001;
    wire logic [13:0] cap      = 14'(cap_prod * {14'h0000, wa});
    wire logic [14:0] lvl_add  = level_r + {10'h000, wa};
    assign fifo_full  = is_fifo && (lvl_add > {1'b0, cap});
    assign fifo_empty = is_fifo && (level_r < {10'h000, wb});

    // Port qualification per mode; port A writes and port B reads in PDP and FIFO.
    wire logic a_rd_ok = go && ce_a && sel_a && !we_a && (is_sp || is_tdp);      // [RQ1]
    wire logic a_wr_ok = go && ce_a && sel_a && we_a && !fifo_full;
    wire logic b_rd_ok = go && ce_b && sel_b && !is_sp                            // [RQ12]
                         && (is_tdp ? !we_b : !fifo_empty);
    wire logic b_wr_ok = go && ce_b && sel_b && we_b && is_tdp;                   // [RQ12]
    wire logic a_desel = go && ce_a && !sel_a;                                    // [RQ11]
    wire logic b_desel = go && ce_b && !sel_b;                                    // [RQ11]
    wire logic push    = is_fifo && a_wr_ok;
    wire logic pop     = is_fifo && b_rd_ok;

    // Word n of a W-bit port starts at bit n*W, whatever the other port uses.
    wire logic [17:0] prod_a = {5'h00, addr_a & ebm_mask_of(width_a)} * {13'h0000, wa};  // [RQ4]
    wire logic [17:0] prod_b = {5'h00, addr_b & ebm_mask_of(width_b)} * {13'h0000, wb};  // [RQ3]
    wire logic [13:0] off_a  = is_fifo ? wptr_r : prod_a[13:0];
    wire logic [13:0] off_b  = is_fifo ? rptr_r : prod_b[13:0];

    wire logic [14:0] wsum    = {1'b0, wptr_r} + {10'h000, wa};
    wire logic [14:0] rsum    = {1'b0, rptr_r} + {10'h000, wb};
    wire logic [13:0] wptr_nxt = (wsum >= {1'b0, cap}) ? 14'(wsum - {1'b0, cap}) : wsum[13:0];
    wire logic [13:0] rptr_nxt = (rsum >= {1'b0, cap}) ? 14'(rsum - {1'b0, cap}) : rsum[13:0];
    wire logic [14:0] level_nxt = level_r + (push ? {10'h000, wa} : 15'h0000)
                                          - (pop ? {10'h000, wb} : 15'h0000);

    // Preload walks 512 words of 18 bits; a zero image never touches the flash.
    wire logic        req_go   = (state_r == ST_LOAD) && preload_en && !issued_r;
    wire logic        load_wr  = pend_r;
    wire logic [17:0] load_dat = preload_zero ? 18'h0_0000 : flash_rdata;        // [RQ6]
    wire logic [13:0] load_off = 14'({5'h00, pend_idx_r} * 14'h0012);
    wire logic        load_end = pend_r && (pend_idx_r == EBM_INIT_LAST);
    assign flash_rd_req = req_go && !preload_zero;                               // [RQ6]
    assign flash_addr   = image_base + {7'h00, idx_r};                           // [RQ7]
    assign ready        = run;
    assign cfg_error    = !cfg_ok;

    ebm_port #(.DW(EBM_DW), .OW(EBM_OW)) u_port_a (
        .clk        (clk),
        .arst_n     (arst_n),
        .rd_req     (a_rd_ok),
        .wr_req     (a_wr_ok),
        .desel_req  (a_desel),
        .off        (off_a),
        .wdata      (wdata_a),
        .out_reg_en (out_reg_a),
        .arr_data   (arr_a),
        .wr_r       (wr_ra),
        .off_r      (off_ra),
        .wdata_r    (wdata_ra),
        .rdata      (rdata_a),
        .rvalid     (rvalid_a)
    );

    ebm_port #(.DW(EBM_DW), .OW(EBM_OW)) u_port_b (
        .clk        (clk),
        .arst_n     (arst_n),
        .rd_req     (b_rd_ok),
        .wr_req     (b_wr_ok),
        .desel_req  (b_desel),
        .off        (off_b),
        .wdata      (wdata_b),
        .out_reg_en (out_reg_b),
        .arr_data   (arr_b),
        .wr_r       (wr_rb),
        .off_r      (off_rb),
        .wdata_r    (wdata_rb),
        .rdata      (rdata_b),
        .rvalid     (rvalid_b)
    );

    always_comb begin
        arr_a = '0;
        arr_b = '0;
        for (int i = 0; i < EBM_DW; i++) begin
            if (i < int'(wa)) begin
                arr_a[i] = mem[int'(off_ra) + i];  // [RQ4]
            end
            if (i < int'(wb)) begin
                arr_b[i] = mem[int'(off_rb) + i];  // [RQ4]
            end
        end
    end

    // The array has no reset; its contents come only from preload or writes.
    always_ff @(posedge clk) begin
        if (load_wr) begin
            for (int i = 0; i < EBM_DW; i++) begin
                mem[int'(load_off) + i] <= load_dat[i];  // [RQ5]
            end
        end else begin
            for (int i = 0; i < EBM_DW; i++) begin
                if (wr_ra && i < int'(wa)) begin
                    mem[int'(off_ra) + i] <= wdata_ra[i];
                end
                if (wr_rb && i < int'(wb)) begin
                    mem[int'(off_rb) + i] <= wdata_rb[i];  // [RQ12]
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= ST_LOAD;
            idx_r      <= '0;
            issued_r   <= 1'b0;
            pend_r     <= 1'b0;
            pend_idx_r <= '0;
        end else begin
            pend_r     <= req_go;
            pend_idx_r <= idx_r;
            if (req_go) begin
                idx_r    <= idx_r + 9'h001;
                issued_r <= (idx_r == EBM_INIT_LAST);
            end
            if (state_r == ST_LOAD && (!preload_en || load_end)) begin
                state_r <= ST_RUN;  // [RQ5]
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_r     <= '0;
            rptr_r     <= '0;
            level_r    <= '0;
            load_cnt_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_nxt;
            end
            if (pop) begin
                rptr_r <= rptr_nxt;
            end
            level_r <= level_nxt;  // [RQ1]
            if (!run && load_cnt_r != 10'h3ff) begin
                load_cnt_r <= load_cnt_r + 10'h001;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_byp_wait;
        1'b1 ##1 rvalid_a;
    endsequence

    sequence s_oreg_wait;
        1'b1 ##1 !rvalid_a ##1 rvalid_a;
    endsequence

    rd_bypass_a: assert property ((a_rd_ok && !out_reg_a) |-> ##1 s_byp_wait) // [RQ10]
        else $error("bypassed read data not valid two clocks after request");
    // Only the first read of a burst is checked, since a read just before it is valid then.
    rd_oreg_a: assert property ((a_rd_ok && out_reg_a && !$past(a_rd_ok)) // [RQ10]
        |-> ##1 s_oreg_wait)
        else $error("registered read data not one clock later than bypass");
    input_capture_a: assert property (a_wr_ok |=> (wr_ra && off_ra == $past(off_a) // [RQ9]
        && wdata_ra == $past(wdata_a)))
        else $error("write address or data not captured at array input");
    wide_illegal_a: assert property ((!is_pdp && !is_fifo && width_a == WID_X18) // [RQ2]
        |-> (cfg_error && !a_wr_ok && !a_rd_ok))
        else $error("18-bit width accepted outside pseudo dual port or FIFO");
    zero_noflash_a: assert property ((preload_zero && !run) |-> !flash_rd_req) // [RQ6]
        else $error("zero image read the user flash store");
    flash_shared_a: assert property ((flash_rd_req ##1 flash_rd_req) // [RQ7]
        |-> flash_addr == $past(flash_addr) + 16'h0001)
        else $error("flash request outside the image region");
    load_bound_a: assert property (load_cnt_r <= EBM_LOAD_MAX) // [RQ5]
        else $error("preload did not finish in time");
    dual_write_a: assert property ((a_wr_ok && b_wr_ok) |=> (wr_ra && wr_rb)) // [RQ12]
        else $error("simultaneous port writes not both taken");
    desel_zero_a: assert property ((a_desel && !out_reg_a && !a_rd_ok) // [RQ11]
        |-> ##2 (rdata_a == 18'h0_0000))
        else $error("deselected port did not return zero");
    fifo_guard_a: assert property (is_fifo |-> level_r <= {1'b0, cap}) // [RQ1]
        else $error("push accepted while full");

endmodule

/* File: bench/ebm_flash_model.sv */
// Purpose: Behavioural user flash store that feeds the block's start-up preload.
// Assumes: One word is requested per clock and is wanted on the following clock.
// Notes: Outside a requested cycle the data toggles, so a stale word never looks valid.
`timescale 1ns/100ps
module ebm_flash_model (
    input  wire logic        clk,
    input  wire logic        flash_rd_req,
    input  wire logic [15:0] flash_addr,
    output logic [17:0]      flash_rdata
);
    initial flash_rdata = 18'h0_0000;
    // Each word depends on its address only, so blocks that share a base share one image.
    always @(posedge clk) begin
        if (flash_rd_req) begin
            flash_rdata <= {flash_addr[1:0], flash_addr} ^ 18'h2_a5c3;
        end else begin
            flash_rdata <= ~flash_rdata;
        end
    end
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the embedded block memory.
// Assumes: Configuration inputs change only while the block is held in reset.
// Notes: Array contents are written before they are read, since they start undefined.
`timescale 1ns/100ps
module tb_top
    import ebm_pkg::*;
;
    logic        clk, arst_n, out_reg_a, out_reg_b, preload_en, preload_zero;
    ebm_mode_t   mode;
    ebm_width_t  width_a, width_b;
    logic        ce_a, sel_a, we_a, ce_b, sel_b, we_b, rvalid_a, rvalid_b;
    logic        flash_rd_req, ready, cfg_error, fifo_full, fifo_empty;
    logic [12:0] addr_a, addr_b;
    logic [15:0] image_base, flash_addr, faddr0, f;
    logic [17:0] wdata_a, wdata_b, rdata_a, rdata_b, flash_rdata, qa, qb;
    int          mismatches, tests_run, cycles, la, lb, pulses;

    ebm_block dut (
        .clk(clk), .arst_n(arst_n), .mode(mode), .width_a(width_a), .width_b(width_b),
        .out_reg_a(out_reg_a), .out_reg_b(out_reg_b), .preload_en(preload_en),
        .preload_zero(preload_zero), .image_base(image_base), .ce_a(ce_a), .sel_a(sel_a),
        .we_a(we_a), .addr_a(addr_a), .wdata_a(wdata_a), .rdata_a(rdata_a),
        .rvalid_a(rvalid_a), .ce_b(ce_b), .sel_b(sel_b), .we_b(we_b), .addr_b(addr_b),
        .wdata_b(wdata_b), .rdata_b(rdata_b), .rvalid_b(rvalid_b),
        .flash_rd_req(flash_rd_req), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .ready(ready), .cfg_error(cfg_error), .fifo_full(fifo_full), .fifo_empty(fifo_empty)
    );

    ebm_flash_model flash (
        .clk(clk), .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic test_done();
        $display("compares %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The whole run needs well under this many cycles; reaching it means a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic [3:0] m, input logic [2:0] wa, input logic [2:0] wb,
                       input logic orr, input logic pe, input logic pz);
        int i;
        @(posedge clk);
        arst_n <= 1'b0;
        mode <= ebm_mode_t'(m);
        width_a <= ebm_width_t'(wa);
        width_b <= ebm_width_t'(wb);
        out_reg_a <= orr;
        out_reg_b <= orr;
        preload_en <= pe;
        preload_zero <= pz;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        pulses = 0;
        #1;
        for (i = 0; i < 600 && ready !== 1'b1; i++) begin
            if (flash_rd_req === 1'b1) begin
                if (pulses == 0) faddr0 = flash_addr;
                pulses++;
            end
            @(posedge clk);
            #1;
        end
        chk({17'h0_0000, ready}, 18'h0_0001);
    endtask

    // One request on either or both ports, then up to four clocks watching for read data.
    task automatic go(input logic ea, input logic wa, input logic [12:0] aa,
                      input logic [17:0] da, input logic eb, input logic wb,
                      input logic [12:0] ab, input logic [17:0] db);
        int i;
        @(posedge clk);
        ce_a <= ea;
        we_a <= wa;
        addr_a <= aa;
        wdata_a <= da;
        ce_b <= eb;
        we_b <= wb;
        addr_b <= ab;
        wdata_b <= db;
        @(posedge clk);
        ce_a <= 1'b0;
        ce_b <= 1'b0;
        we_a <= 1'b0;
        we_b <= 1'b0;
        sel_a <= 1'b1;
        la = 0;
        lb = 0;
        qa = 18'h3_ffff;
        qb = 18'h3_ffff;
        for (i = 1; i < 5; i++) begin
            @(posedge clk);
            #1;
            if (rvalid_a === 1'b1 && la == 0) begin
                la = i;
                qa = rdata_a;
            end
            if (rvalid_b === 1'b1 && lb == 0) begin
                lb = i;
                qb = rdata_b;
            end
        end
    endtask

    task automatic t_table();
        int m;
        int w;
        for (m = 0; m < 4; m++) begin
            for (w = 0; w < 5; w++) begin
                @(posedge clk);
                mode <= ebm_mode_t'(4'h1 << m);
                width_a <= ebm_width_t'(w[2:0]);
                width_b <= ebm_width_t'(w[2:0]);
                @(negedge clk);
                chk({17'h0_0000, cfg_error}, {17'h0_0000, w == 4 && m < 2});
            end
        end
        $display("test table done");
    endtask

    task automatic t_preload();
        int i;
        cfg(4'h4, 3'h4, 3'h4, 1'b0, 1'b1, 1'b0);
        chk(pulses[17:0], 18'h0_0200);
        chk({2'h0, faddr0}, 18'h0_0100);
        for (i = 0; i < 3; i++) begin
            // Write controls stay low after the preload, as for read-only use.
            go(1'b0, 1'b0, 13'h0000, 18'h0_0000, 1'b1, 1'b0, 13'(i * 255), 18'h0_0000);
            f = 16'h0100 + 16'(i * 255);
            chk(qb, {f[1:0], f} ^ 18'h2_a5c3);
            chk(lb[17:0], 18'h0_0001);
        end
        cfg(4'h4, 3'h4, 3'h4, 1'b0, 1'b1, 1'b1);
        chk(pulses[17:0], 18'h0_0000);
        go(1'b0, 1'b0, 13'h0000, 18'h0_0000, 1'b1, 1'b0, 13'h0007, 18'h0_0000);
        chk(qb, 18'h0_0000);
        $display("test preload done");
    endtask

    task automatic t_latency();
        cfg(4'h1, 3'h3, 3'h3, 1'b1, 1'b0, 1'b0);
        go(1'b1, 1'b1, 13'h0003, 18'h0_01a5, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        go(1'b1, 1'b0, 13'h0003, 18'h0_0000, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        chk(qa, 18'h0_01a5);
        chk(la[17:0], 18'h0_0002);
        $display("test latency done");
    endtask

    task automatic t_mixed();
        int k;
        cfg(4'h2, 3'h3, 3'h0, 1'b0, 1'b0, 1'b0);
        go(1'b1, 1'b1, 13'h0000, 18'h0_0000, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        go(1'b1, 1'b1, 13'h0001, 18'h0_00b3, 1'b1, 1'b1, 13'h0000, 18'h0_0001);
        for (k = 0; k < 9; k++) begin
            go(1'b1, 1'b0, 13'h0001, 18'h0_0000, 1'b1, 1'b0, 13'(9 + k), 18'h0_0000);
            chk(qb, {17'h0_0000, 1'(9'h0b3 >> k)});
            chk(qa, 18'h0_00b3);
        end
        go(1'b1, 1'b0, 13'h0000, 18'h0_0000, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        chk(qa, 18'h0_0001);
        @(posedge clk);
        sel_a <= 1'b0;
        go(1'b1, 1'b0, 13'h0001, 18'h0_0000, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        chk(rdata_a, 18'h0_0000);
        $display("test mixed done");
    endtask

    task automatic t_fifo();
        cfg(4'h8, 3'h3, 3'h3, 1'b0, 1'b0, 1'b0);
        chk({17'h0_0000, fifo_empty}, 18'h0_0001);
        go(1'b1, 1'b1, 13'h0000, 18'h0_0155, 1'b0, 1'b0, 13'h0000, 18'h0_0000);
        chk({17'h0_0000, fifo_empty}, 18'h0_0000);
        go(1'b0, 1'b0, 13'h0000, 18'h0_0000, 1'b1, 1'b0, 13'h0000, 18'h0_0000);
        chk(qb, 18'h0_0155);
        chk({17'h0_0000, fifo_empty}, 18'h0_0001);
        // 1024 nine-bit words fill the block; the extra push at the end must be refused.
        @(posedge clk);
        ce_a <= 1'b1;
        we_a <= 1'b1;
        wdata_a <= 18'h0_00c6;
        repeat (1025) @(posedge clk);
        ce_a <= 1'b0;
        we_a <= 1'b0;
        @(negedge clk);
        chk({17'h0_0000, fifo_full}, 18'h0_0001);
        go(1'b0, 1'b0, 13'h0000, 18'h0_0000, 1'b1, 1'b0, 13'h0000, 18'h0_0000);
        chk(qb, 18'h0_00c6);
        chk({17'h0_0000, fifo_full}, 18'h0_0000);
        $display("test fifo done");
    endtask

    initial begin
        arst_n = 1'b0;
        mode = MODE_SINGLE;
        width_a = WID_X1;
        width_b = WID_X1;
        {out_reg_a, out_reg_b, preload_en, preload_zero} = 4'h0;
        image_base = 16'h0100;
        {ce_a, we_a, ce_b, we_b} = 4'h0;
        {sel_a, sel_b} = 2'h3;
        addr_a = 13'h0000;
        addr_b = 13'h0000;
        wdata_a = 18'h0_0000;
        wdata_b = 18'h0_0000;
        repeat (20) @(posedge clk);
        t_table();
        t_preload();
        t_latency();
        t_mixed();
        t_fifo();
        test_done();
    end
endmodule
